// ### dv/host_model.sv
`timescale 1ns/1ps
// ****************************************
// register host, one byte per access
// ****************************************
module host_model (
   input  wire logic       clk,        // clock
   output logic      [7:0] reg_addr,   // address
   output logic            reg_wr,     // write strobe
   output logic      [7:0] reg_wdata,  // write data
   output logic            reg_rd,     // read strobe
   input  wire logic [7:0] reg_rdata,  // read data
   input  wire logic       reg_rvalid  // read valid
);
   initial begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_wdata = 8'h00;
      reg_rd = 1'b0;
   end
   task wr(input logic [7:0] a, d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
      // stale data inverted so a late sample shows
      reg_wdata = ~d;
   endtask
   task rd(input logic [7:0] a, output logic [7:0] d);
      int n;
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      n = 0;
      // answer stands for one cycle only, so look before waiting
      while (reg_rvalid !== 1'b1 && n < 4) begin
         @(negedge clk);
         n++;
      end
      d = reg_rdata;
   endtask
endmodule

// ### dv/monitor_regs_properties.sv
`timescale 1ns/1ps
// ****************************************
// port checks of the register bank
// ****************************************
module monitor_regs_chk (
   input wire logic       clk,          // clock
   input wire logic       rst,          // sync reset
   input wire logic [7:0] reg_addr,     // address
   input wire logic       reg_wr,       // write strobe
   input wire logic [7:0] reg_wdata,    // write data
   input wire logic       reg_rd,       // read strobe
   input wire logic [7:0] reg_rdata,    // read data
   input wire logic       reg_rvalid,   // read valid
   input wire logic       conv_halt,    // unlock level
   input wire logic [7:0] alert_enable, // alert enables
   input wire logic [7:0] limit_flags,  // live flags
   input wire logic [7:0] limit_faults  // latched faults
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   chk_read_answer: assert property (reg_rd |=> reg_rvalid)
      else $error("read not answered next cycle");
   chk_rvalid_pulse: assert property (!reg_rd |=> !reg_rvalid)
      else $error("read valid without read");
   chk_status_read: assert property (reg_rd && reg_addr == 8'h02
      |=> reg_rdata == $past(limit_flags))
      else $error("status read differs from flags");
   chk_fault_read: assert property (reg_rd && reg_addr == 8'h03
      |=> reg_rdata == $past(limit_faults))
      else $error("fault read differs from faults");
   chk_fault_sticky: assert property (!$past(rst)
      && !($past(reg_wr) && $past(reg_addr) == 8'h03)
      |-> (limit_faults & $past(limit_faults)) == $past(limit_faults))
      else $error("fault bit cleared without host write");
   chk_flags_latched: assert property ($changed(limit_flags)
      && !$past(rst) |-> (limit_flags & ~limit_faults) == 8'h00)
      else $error("set flag not latched as fault");
   chk_unlock_set: assert property (reg_wr && reg_addr == 8'h00
      && reg_wdata[4] |=> conv_halt)
      else $error("unlock write did not halt");
   chk_unlock_clear: assert property (reg_wr && reg_addr == 8'h00
      && !reg_wdata[4] |=> !conv_halt)
      else $error("lock write did not resume");
   chk_alert_write: assert property (reg_wr && reg_addr == 8'h01
      |=> alert_enable == $past(reg_wdata))
      else $error("alert enable not stored");
   chk_low_reserved: assert property (reg_rd && reg_addr[0]
      && reg_addr[7:4] >= 4'h2 && reg_addr[7:4] <= 4'h4
      && reg_addr[3:0] <= 4'h9 |=> reg_rdata[3:0] == 4'h0)
      else $error("reserved low nibble not zero");
endmodule
bind monitor_regs monitor_regs_chk u_chk (.clk(clk), .rst(rst),
   .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
   .conv_halt(conv_halt), .alert_enable(alert_enable),
   .limit_flags(limit_flags), .limit_faults(limit_faults));

// ### dv/monitor_status_fault_data_regs_tb_top.sv
`timescale 1ns/1ps
module monitor_status_fault_data_regs_tb_top;
   logic clk = 1'b0, rst = 1'b1, meas_valid = 1'b0, halt = 1'b0;
   logic [1:0] meas_qty = 2'h0;
   logic [23:0] meas_data = 24'h000000, d;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, got8, fexp;
   logic [7:0] alert_enable, limit_flags, limit_faults;
   logic reg_wr, reg_rd, reg_rvalid, conv_halt;
   logic [23:0] res[4], tmax[4], tmin[4];
   int failures = 0, comparisons = 0, cycles = 0, q;
   integer seed = 32'hf16c;
   always #5 clk = ~clk;
   monitor_regs DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .meas_valid(meas_valid), .meas_qty(meas_qty),
      .meas_data(meas_data), .conv_halt(conv_halt),
      .alert_enable(alert_enable), .limit_flags(limit_flags),
      .limit_faults(limit_faults));
   host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid));
   // ****************************************
   // checking helpers
   // ****************************************
   task chk(input logic [23:0] got, exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   function automatic logic [7:0] exp_flags();
      logic [7:0] f;
      f = 8'h00;
      for (int i = 0; i < 4; i++) begin
         f[7-2*i] = res[i] > tmax[i];
         f[6-2*i] = res[i] < tmin[i];
      end
      return f;
   endfunction
   task flagchk();
      fexp = fexp | exp_flags();
      chk(limit_flags, exp_flags());
      chk(limit_faults, fexp);
   endtask
   // write or read back one value word, byte 0 most significant
   task automatic xfer(input bit w_en, input int qt, w, logic [23:0] v);
      logic [23:0] b;
      logic [7:0] a, g;
      int n;
      b = (qt == 0) ? v : {v[11:0], 12'h000};
      n = (qt == 0) ? 3 : 2;
      a = 8'(16 + 16 * qt + n * w);
      for (int i = 0; i < n; i++) begin
         if (w_en) host.wr(a + 8'(i), b[23-8*i -: 8]);
         else host.rd(a + 8'(i), g);
         if (!w_en) chk(g, b[23-8*i -: 8]);
      end
   endtask
   task automatic meas(input int qt, input logic [23:0] v);
      @(negedge clk);
      meas_qty = 2'(qt);
      meas_data = v;
      meas_valid = 1'b1;
      @(negedge clk);
      meas_valid = 1'b0;
      meas_data = ~v;
      if (!halt) res[qt] = (qt == 0) ? v : v & 24'h000FFF;
      @(negedge clk);
      flagchk();
   endtask
   task wrap_up();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles > 8000) begin
         failures++;
         wrap_up();
      end
   end
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      fexp = 8'h00;
      repeat (3) @(negedge clk);
      rst = 1'b0;
      host.rd(8'h00, got8);
      chk(got8, 8'h05);
      chk(conv_halt, 1'b0);
      host.rd(8'h01, got8);
      chk(got8, 8'h00);
      host.rd(8'h03, got8);
      chk(got8, 8'h00);
      xfer(0, 1, 3, 24'h000FFF);
      xfer(0, 0, 3, 24'hFFFFFF);
      xfer(0, 1, 2, 24'h000FFF);
      for (q = 0; q < 4; q++) begin
         res[q] = 24'h000000;
         tmax[q] = q ? 24'h000400 : 24'h001000;
         tmin[q] = q ? 24'h000100 : 24'h000100;
         xfer(1, q, 3, tmax[q]);
         xfer(1, q, 4, tmin[q]);
         xfer(0, q, 4, tmin[q]);
      end
      host.wr(8'h01, 8'h81);
      chk(alert_enable, 8'h81);
      repeat (24) begin
         q = {$random(seed)} % 4;
         case ({$random(seed)} % 5)
            0: d = tmax[q];
            1: d = tmax[q] + 24'h1;
            2: d = tmin[q];
            3: d = tmin[q] - 24'h1;
            default: d = $random(seed);
         endcase
         meas(q, d);
         xfer(0, q, 0, res[q]);
      end
      host.wr(8'h02, 8'hFF);
      host.rd(8'h02, got8);
      chk(got8, exp_flags());
      host.wr(8'h03, 8'h00);
      host.rd(8'h03, got8);
      chk(got8, 8'h00);
      host.wr(8'h03, 8'hA5);
      fexp = 8'hA5;
      host.rd(8'h03, got8);
      chk(got8, 8'hA5);
      meas(1, 24'h000500);
      host.wr(8'h00, 8'h15);
      halt = 1'b1;
      chk(conv_halt, 1'b1);
      meas(3, 24'h000FFF);
      res[2] = 24'h000050;
      xfer(1, 2, 0, res[2]);
      repeat (2) @(negedge clk);
      flagchk();
      res[0] = 24'h123456;
      xfer(1, 0, 0, res[0]);
      repeat (2) @(negedge clk);
      flagchk();
      host.wr(8'h00, 8'h05);
      halt = 1'b0;
      xfer(1, 2, 0, 24'h000FFF);
      xfer(0, 2, 0, res[2]);
      host.rd(8'hFF, got8);
      chk(got8, 8'h00);
      wrap_up();
   end
endmodule

// ### hw/flag_if.sv
`timescale 1ns/1ps
interface flag_if;
   logic       eval;
   logic [3:0] over;
   logic [3:0] under;

   modport src (output eval, output over, output under);
   modport dst (input eval, input over, input under);
endinterface

// ### hw/flag_latch.sv
`timescale 1ns/1ps
`include "monitor_consts.svh"
module flag_latch (
   input  wire logic       clk,          // device clock
   input  wire logic       rst,          // sync reset, high
   flag_if.dst             cmp,          // comparison results
   input  wire logic       fault_wr,     // host write to faults
   input  wire logic [7:0] fault_wdata,  // host write data
   output logic      [7:0] flags,        // live flags
   output logic      [7:0] faults        // latched faults
);
   logic [7:0] cmp_byte;
   logic [7:0] next_faults;

   genvar q;
   generate
      for (q = 0; q < 4; q++) begin : g_pair
         assign cmp_byte[7-2*q] = cmp.over[q];
         assign cmp_byte[6-2*q] = cmp.under[q];
      end
   endgenerate

   // ********************************************************
   // live flags
   // ********************************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         flags <= `FLAGS_RESET;
      end else if (cmp.eval) begin
         flags <= cmp_byte;
      end
   end

   // ********************************************************
   // latched faults
   // ********************************************************
   always_comb begin
      next_faults = fault_wr ? fault_wdata : faults;
      // a new event wins over a host clear in the same cycle
      if (cmp.eval) begin
         next_faults = next_faults | cmp_byte;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         faults <= `FAULTS_RESET;
      end else begin
         faults <= next_faults;
      end
   end
endmodule

// ### hw/limit_check.sv
`timescale 1ns/1ps
module limit_check (
   input  wire logic [23:0] value,    // stored result, low aligned
   input  wire logic [23:0] thr_max,  // upper threshold
   input  wire logic [23:0] thr_min,  // lower threshold
   output logic             over,     // value above upper
   output logic             under     // value below lower
);
   always_comb begin
      over  = value > thr_max;
      under = value < thr_min;
   end
endmodule

// ### hw/monitor_consts.svh
`ifndef MONITOR_CONSTS_SVH
`define MONITOR_CONSTS_SVH

// ********************************************************
// byte offsets on the register port
// ********************************************************
`define OFS_CTRL           8'h00
`define OFS_ALERT_EN       8'h01
`define OFS_LIMIT_FLAGS    8'h02
`define OFS_LIMIT_FAULTS   8'h03
`define OFS_VALUE_BASE     8'h10
`define OFS_VALUE_STRIDE   8'h10

// ********************************************************
// field positions
// ********************************************************
`define CTRL_UNLOCK_BIT    4
`define CTRL_BUSY_BIT      3
`define CTRL_WMASK         8'hF7
`define LOW_NIBBLE_POS     4

// ********************************************************
// reset values
// ********************************************************
`define CTRL_RESET         8'h05
`define ALERT_EN_RESET     8'h00
`define FLAGS_RESET        8'h00
`define FAULTS_RESET       8'h00
`define MAX_SEEN_RESET     24'h000000
`define MIN_SEEN_RESET     24'hFFFFFF
`define THR_MAX_RESET      24'hFFFFFF
`define THR_MIN_RESET      24'h000000
`define WIDE_MASK          24'hFFFFFF
`define NARROW_MASK        24'h000FFF

`endif

// ### hw/monitor_pkg.sv
package monitor_pkg;

   typedef enum logic [1:0] {
      QTY_POWER = 2'h0,
      QTY_SENSE = 2'h1,
      QTY_VIN   = 2'h2,
      QTY_AUX   = 2'h3
   } qty_t;

   typedef enum logic [2:0] {
      WORD_RESULT   = 3'h0,
      WORD_MAX_SEEN = 3'h1,
      WORD_MIN_SEEN = 3'h2,
      WORD_THR_MAX  = 3'h3,
      WORD_THR_MIN  = 3'h4
   } word_t;

   typedef struct packed {
      logic       hit;
      logic [1:0] qty;
      logic [2:0] word;
      logic [1:0] byte_sel;
   } value_addr_t;

endpackage

// ### hw/monitor_regs.sv
`timescale 1ns/1ps
`include "monitor_consts.svh"
// Summary of operation
// - status bit 7 reads 1 while power exceeds its upper threshold
// - status bit 6 reads 1 while power is below its lower threshold
// - status bits 5..0 give over/under pairs for sense, input, aux
// - status bit 0 reads 1 while aux is below its lower threshold
// - status byte is read only; writes leave live flags untouched
// - fault bit 7 records that power was ever above its upper threshold
// - fault bit 6 records that power was ever below its lower threshold
// - fault bits 5..0 record past events, same order as status
// - fault byte is readable and writable by the host
// - twelve-bit high byte carries data bits 11..4
// - twelve-bit low byte carries bits 3..0 on top, zeros below
// - power values span three bytes, top byte holds bits 23..16
// - power middle byte holds 15..8, bottom byte holds 7..0
// - test unlock halts conversions, opens result writes, resets off
// - alert enable byte has one bit per flag, all off at reset
module monitor_regs
   import monitor_pkg::*;
(
   input  wire logic        clk,          // device clock, 100 MHz
   input  wire logic        rst,          // sync reset, high
   input  wire logic [7:0]  reg_addr,     // register byte address
   input  wire logic        reg_wr,       // write strobe
   input  wire logic [7:0]  reg_wdata,    // write data
   input  wire logic        reg_rd,       // read strobe
   output logic      [7:0]  reg_rdata,    // read data
   output logic             reg_rvalid,   // read data valid pulse
   input  wire logic        meas_valid,   // conversion done pulse
   input  wire logic [1:0]  meas_qty,     // quantity converted
   input  wire logic [23:0] meas_data,    // converted value
   output logic             conv_halt,    // conversions halted
   output logic      [7:0]  alert_enable, // alert enable byte
   output logic      [7:0]  limit_flags,  // live limit flags
   output logic      [7:0]  limit_faults  // latched limit faults
);

   // ********************************************************
   // address helpers
   // ********************************************************
   function automatic value_addr_t decode_value(input logic [7:0] a);
      value_addr_t d;
      logic [7:0]  rel;
      logic [3:0]  off;
      logic [3:0]  nbytes;
      d   = '0;
      rel = a - `OFS_VALUE_BASE;
      off = rel[3:0];
      nbytes = (rel[5:4] == QTY_POWER) ? 4'h3 : 4'h2;
      if (a >= `OFS_VALUE_BASE && rel[7:6] == 2'h0
          && off < 4'(nbytes * 4'h5)) begin
         d.hit      = 1'b1;
         d.qty      = rel[5:4];
         d.word     = 3'(off / nbytes);
         d.byte_sel = 2'(off % nbytes);
      end
      return d;
   endfunction

   function automatic logic [23:0] width_mask(input logic [1:0] q);
      return (q == QTY_POWER) ? `WIDE_MASK : `NARROW_MASK;
   endfunction

   function automatic logic [7:0] get_byte(input logic [23:0] v,
                                           input logic [1:0]  q,
                                           input logic [1:0]  b);
      logic [7:0] r;
      r = 8'h00;
      if (q == QTY_POWER) begin
         unique case (b)
            2'h0:    r = v[23:16];
            2'h1:    r = v[15:8];
            default: r = v[7:0];
         endcase
      end else if (b == 2'h0) begin
         r = v[11:4];
      end else begin
         r = {v[3:0], 4'h0};
      end
      return r;
   endfunction

   function automatic logic [23:0] put_byte(input logic [23:0] v,
                                            input logic [1:0]  q,
                                            input logic [1:0]  b,
                                            input logic [7:0]  d);
      logic [23:0] r;
      r = v;
      if (q == QTY_POWER) begin
         unique case (b)
            2'h0:    r[23:16] = d;
            2'h1:    r[15:8]  = d;
            default: r[7:0]   = d;
         endcase
      end else if (b == 2'h0) begin
         r[11:4] = d;
      end else begin
         r[3:0] = d[7:`LOW_NIBBLE_POS];
      end
      return r;
   endfunction

   // ********************************************************
   // control and alert enable
   // ********************************************************
   logic [7:0] ctrl;
   logic       unlock;

   assign unlock       = ctrl[`CTRL_UNLOCK_BIT];
   assign conv_halt    = ctrl[`CTRL_UNLOCK_BIT];

   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl <= `CTRL_RESET;
      end else if (reg_wr && reg_addr == `OFS_CTRL) begin
         // busy bit is status only, never stored
         ctrl <= reg_wdata & `CTRL_WMASK;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         alert_enable <= `ALERT_EN_RESET;
      end else if (reg_wr && reg_addr == `OFS_ALERT_EN) begin
         alert_enable <= reg_wdata;
      end
   end

   // ********************************************************
   // write qualification
   // ********************************************************
   value_addr_t wdec;
   logic        thr_word;
   logic        host_value_wr;
   logic        conv_ok;
   logic        result_wr;

   always_comb begin
      wdec     = decode_value(reg_addr);
      thr_word = (wdec.word == WORD_THR_MAX)
               || (wdec.word == WORD_THR_MIN);
      // measured values are only writable with conversions halted
      host_value_wr = reg_wr && wdec.hit && (thr_word || unlock);
      conv_ok       = meas_valid && !unlock;
      result_wr     = host_value_wr && wdec.word == WORD_RESULT;
   end

   // ********************************************************
   // value storage
   // ********************************************************
   logic [23:0] result   [4];
   logic [23:0] max_seen [4];
   logic [23:0] min_seen [4];
   logic [23:0] thr_max  [4];
   logic [23:0] thr_min  [4];
   logic [23:0] sample;

   // declared ahead of the per-quantity checkers that drive it
   flag_if cmp ();

   assign sample = meas_data & width_mask(meas_qty);

   genvar q;
   generate
      for (q = 0; q < 4; q++) begin : g_qty
         logic       hit_q;
         logic       conv_q;
         logic [1:0] qi;

         assign qi     = 2'(q);
         assign hit_q  = host_value_wr && wdec.qty == qi;
         assign conv_q = conv_ok && meas_qty == qi;

         always_ff @(posedge clk) begin
            if (rst) begin
               result[q] <= 24'h000000;
            end else if (hit_q && wdec.word == WORD_RESULT) begin
               result[q] <= put_byte(result[q], qi,
                                     wdec.byte_sel, reg_wdata);
            end else if (conv_q) begin
               result[q] <= sample;
            end
         end

         always_ff @(posedge clk) begin
            if (rst) begin
               max_seen[q] <= `MAX_SEEN_RESET & width_mask(qi);
            end else if (hit_q && wdec.word == WORD_MAX_SEEN) begin
               max_seen[q] <= put_byte(max_seen[q], qi,
                                       wdec.byte_sel, reg_wdata);
            end else if (conv_q && sample > max_seen[q]) begin
               max_seen[q] <= sample;
            end
         end

         always_ff @(posedge clk) begin
            if (rst) begin
               min_seen[q] <= `MIN_SEEN_RESET & width_mask(qi);
            end else if (hit_q && wdec.word == WORD_MIN_SEEN) begin
               min_seen[q] <= put_byte(min_seen[q], qi,
                                       wdec.byte_sel, reg_wdata);
            end else if (conv_q && sample < min_seen[q]) begin
               min_seen[q] <= sample;
            end
         end

         always_ff @(posedge clk) begin
            if (rst) begin
               thr_max[q] <= `THR_MAX_RESET & width_mask(qi);
            end else if (hit_q && wdec.word == WORD_THR_MAX) begin
               thr_max[q] <= put_byte(thr_max[q], qi,
                                      wdec.byte_sel, reg_wdata);
            end
         end

         always_ff @(posedge clk) begin
            if (rst) begin
               thr_min[q] <= `THR_MIN_RESET;
            end else if (hit_q && wdec.word == WORD_THR_MIN) begin
               thr_min[q] <= put_byte(thr_min[q], qi,
                                      wdec.byte_sel, reg_wdata);
            end
         end

         limit_check u_check (
            .value   (result[q]),
            .thr_max (thr_max[q]),
            .thr_min (thr_min[q]),
            .over    (cmp.over[q]),
            .under   (cmp.under[q])
         );
      end
   endgenerate

   // ********************************************************
   // comparison strobe
   // ********************************************************
   // one cycle late so the compare sees the freshly stored value
   always_ff @(posedge clk) begin
      if (rst) begin
         cmp.eval <= 1'b0;
      end else begin
         cmp.eval <= conv_ok || result_wr;
      end
   end

   flag_latch u_flags (
      .clk         (clk),
      .rst         (rst),
      .cmp         (cmp),
      .fault_wr    (reg_wr && reg_addr == `OFS_LIMIT_FAULTS),
      .fault_wdata (reg_wdata),
      .flags       (limit_flags),
      .faults      (limit_faults)
   );

   // ********************************************************
   // read port
   // ********************************************************
   value_addr_t rdec;
   logic [7:0]  next_rdata;
   logic [23:0] rword;

   always_comb begin
      rdec  = decode_value(reg_addr);
      rword = 24'h000000;
      unique case (word_t'(rdec.word))
         WORD_RESULT:   rword = result[rdec.qty];
         WORD_MAX_SEEN: rword = max_seen[rdec.qty];
         WORD_MIN_SEEN: rword = min_seen[rdec.qty];
         WORD_THR_MAX:  rword = thr_max[rdec.qty];
         WORD_THR_MIN:  rword = thr_min[rdec.qty];
         default:       rword = 24'h000000;
      endcase
      // status has no write path at all, so writes cannot touch it
      if (reg_addr == `OFS_CTRL) begin
         next_rdata = ctrl;
      end else if (reg_addr == `OFS_ALERT_EN) begin
         next_rdata = alert_enable;
      end else if (reg_addr == `OFS_LIMIT_FLAGS) begin
         next_rdata = limit_flags;
      end else if (reg_addr == `OFS_LIMIT_FAULTS) begin
         next_rdata = limit_faults;
      end else if (rdec.hit) begin
         next_rdata = get_byte(rword, rdec.qty, rdec.byte_sel);
      end else begin
         next_rdata = 8'h00;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         reg_rdata  <= 8'h00;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         if (reg_rd) begin
            reg_rdata <= next_rdata;
         end
      end
   end

endmodule
